// >>> dtc_timer_control.sv
// Control register logic of a two-half general-purpose timer.
// Assumes an APB master on pclk; counters, PWM source and ADC live outside.
//
// Operation
// - B edge field picks rising, falling or both edges; code 2 reserved.
// - B freeze bit holds the B counter while the debugger halts the core.
// - B enable low keeps B inactive; high starts counting or arms capture.
// - A PWM invert bit inverts the A PWM output, else passes it.
// - A trigger enable passes the A trigger to the ADC, else holds it low.
// - RTC enable bit runs real-time-clock counting; clear stops it.
// - A edge field uses the same edge encoding as the B field.
// - A freeze bit holds the A counter while the debugger halts the core.
// - A enable low keeps A inactive; high starts counting or arms capture.
// - Reserved control bits read zero; software preserves them on updates.
// - Global config selects 32-bit timer, 32-bit RTC or two 16-bit timers.
// - Control works with configuration; the A trigger can start ADC conversions.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "dtc_defines.svh"

module dtc_timer_control (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Debug and capture inputs.
    input  wire logic        debug_halt,
    input  wire logic        a_capture_pin,
    input  wire logic        b_capture_pin,
    // Sources from the counters.
    input  wire logic        a_pwm_raw,
    input  wire logic        a_timeout_pulse,
    // Controls toward the counters.
    output logic             a_count_en,
    output logic             b_count_en,
    output logic             rtc_count_run,
    output logic             a_capture_event,
    output logic             b_capture_event,
    output logic             cfg_single32,
    output logic             cfg_rtc32,
    output logic             cfg_split16,
    // Outputs toward pins and the ADC.
    output logic             a_pwm_out,
    output logic             a_adc_trigger
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    dtc_pkg::dtc_state_s st_reg;
    dtc_pkg::dtc_state_s st_next;

    logic        setup;
    logic        access;
    logic        wr_cfg;
    logic        wr_ctl;
    logic        hit;
    logic [31:0] strb_mask;
    logic [31:0] ctl_word;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;
    logic        a_en;
    logic        b_en;
    logic        a_freeze;
    logic        b_freeze;
    logic        rtc_en;
    logic        a_frozen;
    logic        b_frozen;
    logic        is_single32;
    logic        is_rtc32;
    logic        is_split16;
    logic [1:0]  edge_sel [2];
    logic [1:0]  cap_pin;
    logic [1:0]  cap_event;
    logic [1:0]  cap_arm;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode.

    // The slave answers in the access cycle with no wait state; read data and the
    // error flag are caught in the setup cycle so that they leave from flip-flops.
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign pready = access;
    assign hit    = (paddr == `DTC_OFF_CFG) | (paddr == `DTC_OFF_CTL) |
                    (paddr == `DTC_OFF_STAT);
    assign wr_cfg = access & pwrite & (paddr == `DTC_OFF_CFG);
    assign wr_ctl = access & pwrite & (paddr == `DTC_OFF_CTL);

    // Byte lane mask built from the write strobes.
    always_comb begin
        strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field views of the stored registers.

    assign a_en     = st_reg.ctl[`DTC_A_EN];
    assign b_en     = st_reg.ctl[`DTC_B_EN];
    assign a_freeze = st_reg.ctl[`DTC_A_FREEZE];
    assign b_freeze = st_reg.ctl[`DTC_B_FREEZE];
    assign rtc_en   = st_reg.ctl[`DTC_RTC_EN];

    // Debug halt is taken as synchronous and sampled on every edge.
    assign a_frozen = debug_halt & a_freeze;
    assign b_frozen = debug_halt & b_freeze;

    // Codes 2 and 3 select no arrangement, so both halves stay idle there.
    assign is_single32 = (st_reg.cfg == `DTC_CFG_T32);
    assign is_rtc32    = (st_reg.cfg == `DTC_CFG_RTC);
    assign is_split16  = st_reg.cfg[2];

    // Read views; reserved bits come back as zero.
    assign ctl_word  = {20'h00000, st_reg.ctl} & `DTC_CTL_RW_MASK;
    assign cfg_word  = {29'h00000000, st_reg.cfg};
    assign stat_word = {26'h0000000, b_frozen, a_frozen, debug_halt,
                        st_reg.rtc_run, st_reg.b_cnt, st_reg.a_cnt};

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // One process computes every flip-flop; register writes land at the access edge.
    always_comb begin
        st_next = st_reg;

        // Control register write; reserved bits are dropped by the mask.
        if (wr_ctl) begin
            st_next.ctl = 12'((ctl_word & ~strb_mask) |
                              (pwdata & strb_mask & `DTC_CTL_RW_MASK));
        end

        // Configuration register write through byte lane 0.
        if (wr_cfg && pstrb[0]) begin
            st_next.cfg = pwdata[2:0];
        end

        // Read data and slave error are captured during setup.
        if (setup) begin
            st_next.err = ~hit;
            case (paddr)
                `DTC_OFF_CFG:  st_next.rdata = cfg_word;
                `DTC_OFF_CTL:  st_next.rdata = ctl_word;
                `DTC_OFF_STAT: st_next.rdata = stat_word;
                default:       st_next.rdata = 32'h00000000;
            endcase
        end

        // Count enables: a half runs when enabled in a 32-bit or split timer arrangement and not
        // frozen by a debug halt. The B half exists only in the split mode.
        st_next.a_cnt = a_en & ~a_frozen & (is_single32 | is_split16);
        st_next.b_cnt = b_en & ~b_frozen & is_split16;

        // RTC counting follows its enable bit in the RTC arrangement; a debug
        // halt with the A freeze bit set holds it as well.
        st_next.rtc_run = rtc_en & is_rtc32 & ~a_frozen;

        // PWM level and ADC trigger gating.
        st_next.pwm  = a_pwm_raw ^ st_reg.ctl[`DTC_A_PWM_INV];
        st_next.trig = a_timeout_pulse & st_reg.ctl[`DTC_A_TRIG_EN];
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg       <= '0;
            st_reg.ctl   <= `DTC_CTL_RST;
            st_reg.cfg   <= `DTC_CFG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture edge selection per half.

    assign edge_sel[0] = st_reg.ctl[`DTC_A_EDGE_HI:`DTC_A_EDGE_LO];
    assign edge_sel[1] = st_reg.ctl[`DTC_B_EDGE_HI:`DTC_B_EDGE_LO];
    assign cap_pin     = {b_capture_pin, a_capture_pin};
    assign cap_arm     = {st_reg.b_cnt, st_reg.a_cnt};

    // Capture arms only while the half counts, so a frozen half misses edges.
    for (genvar h = 0; h < 2; h++) begin : g_half
        dtc_edge_select u_edge (
            .pclk          (pclk),
            .presetn       (presetn),
            .edge_sel      (edge_sel[h]),
            .arm           (cap_arm[h]),
            .pin_in        (cap_pin[h]),
            .capture_event (cap_event[h])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign prdata          = st_reg.rdata;
    assign pslverr         = access & st_reg.err;
    assign a_count_en      = st_reg.a_cnt;
    assign b_count_en      = st_reg.b_cnt;
    assign rtc_count_run   = st_reg.rtc_run;
    assign a_capture_event = cap_event[0];
    assign b_capture_event = cap_event[1];
    assign a_pwm_out       = st_reg.pwm;
    // The ADC decides on its own whether to act on this pulse.
    assign a_adc_trigger   = st_reg.trig;
    assign cfg_single32    = is_single32;
    assign cfg_rtc32       = is_rtc32;
    assign cfg_split16     = is_split16;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_b_freeze_hold: assert property (
        (debug_halt && b_freeze) |=> !b_count_en)
        else $error("B half counted during a frozen debug halt.");

    chk_b_enable_gate: assert property (
        (b_en && !debug_halt && is_split16) |=> b_count_en)
        else $error("Enabled B half did not count.");

    chk_pwm_invert: assert property (
        ##1 (a_pwm_out == ($past(a_pwm_raw) ^ $past(st_reg.ctl[6]))))
        else $error("PWM output level does not follow the invert bit.");

    chk_adc_trig_gate: assert property (
        (a_timeout_pulse && st_reg.ctl[5]) |=> a_adc_trigger)
        else $error("Enabled ADC trigger was not passed.");

    chk_adc_trig_off: assert property (
        !st_reg.ctl[5] |=> !a_adc_trigger)
        else $error("ADC trigger fired while disabled.");

    chk_rtc_run: assert property (
        (rtc_en && is_rtc32 && !a_frozen) |=> rtc_count_run)
        else $error("RTC counting did not follow its enable.");

    chk_a_freeze_hold: assert property (
        (debug_halt && a_freeze) |=> (!a_count_en && !rtc_count_run))
        else $error("A half counted during a frozen debug halt.");

    chk_a_enable_gate: assert property (
        (!a_en) |=> !a_count_en ##0 (a_en || !a_count_en))
        else $error("Disabled A half counted.");

    chk_reserved_zero: assert property (
        (setup && !pwrite && paddr == 12'h00C) |=> (prdata[31:12] == 20'h00000
                                                     && prdata[7] == 1'b0))
        else $error("Reserved control bits did not read as zero.");

    chk_cfg_reserved: assert property (
        (st_reg.cfg == 3'h2 || st_reg.cfg == 3'h3) |=> (!a_count_en && !b_count_en))
        else $error("A half ran in a reserved configuration.");

    chk_ctl_write: assert property (
        (wr_ctl && pstrb[0] && pwdata[0]) |=> a_en)
        else $error("Control write did not set the A enable.");

    // The A half counts in the single arrangement once it is enabled.
    chk_a_enable_on: assert property (
        (a_en && !debug_halt && is_single32) |=> a_count_en)
        else $error("Enabled A half did not count in the single arrangement.");

    // A cleared B enable keeps the B half idle.
    chk_b_enable_off: assert property (
        !b_en |=> !b_count_en)
        else $error("Disabled B half counted.");

    // The B half has nothing to count outside the split arrangement.
    chk_b_split_only: assert property (
        !is_split16 |=> !b_count_en)
        else $error("B half counted outside the split arrangement.");

    // Without a halt the A freeze bit must not stop the count.
    chk_a_freeze_idle: assert property (
        (a_en && a_freeze && !debug_halt && is_split16) |=> a_count_en)
        else $error("A freeze bit stopped the count without a halt.");

    // Without a halt the B freeze bit must not stop the count.
    chk_b_freeze_idle: assert property (
        (b_en && b_freeze && !debug_halt && is_split16) |=> b_count_en)
        else $error("B freeze bit stopped the count without a halt.");

    // A halt alone leaves an unfrozen A half counting.
    chk_a_halt_run: assert property (
        (a_en && !a_freeze && debug_halt && is_split16) |=> a_count_en)
        else $error("Unfrozen A half stopped during a halt.");

    // A halt alone leaves an unfrozen B half counting.
    chk_b_halt_run: assert property (
        (b_en && !b_freeze && debug_halt && is_split16) |=> b_count_en)
        else $error("Unfrozen B half stopped during a halt.");

    // A cleared RTC enable stops the RTC count.
    chk_rtc_stop: assert property (
        !rtc_en |=> !rtc_count_run)
        else $error("RTC counted while disabled.");

    // The trigger never fires without a source pulse.
    chk_trig_idle: assert property (
        !a_timeout_pulse |=> !a_adc_trigger)
        else $error("ADC trigger fired without a source pulse.");

    // A configuration write through lane 0 is stored as written.
    chk_cfg_write: assert property (
        (wr_cfg && pstrb[0]) |=> (st_reg.cfg == $past(pwdata[2:0])))
        else $error("Configuration write was not stored.");

    // Bit 7 is never stored, whatever software writes.
    chk_ctl_bit7_zero: assert property (
        (wr_ctl && pwdata[7]) |=> !st_reg.ctl[7])
        else $error("Reserved control bit 7 was stored.");

    // An idle A half raises no capture event.
    chk_a_capture_arm: assert property (
        !a_count_en |=> !a_capture_event)
        else $error("Idle A half raised a capture event.");

    // An idle B half raises no capture event.
    chk_b_capture_arm: assert property (
        !b_count_en |=> !b_capture_event)
        else $error("Idle B half raised a capture event.");

    // A falling pin edge is caught under the falling code.
    chk_a_fall_event: assert property (
        (edge_sel[0] == 2'h1 && a_count_en && $fell(a_capture_pin)) |=> a_capture_event)
        else $error("Falling edge did not raise the A capture event.");

    // Either pin edge is caught under the both-edges code.
    chk_b_both_event: assert property (
        (edge_sel[1] == 2'h3 && b_count_en && $changed(b_capture_pin)) |=> b_capture_event)
        else $error("Pin edge did not raise the B capture event.");

endmodule : dtc_timer_control

// >>> dtc_defines.svh
// Offsets, field positions and reset values of the dual timer control block.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// Register byte offsets on the APB window.
`define DTC_OFF_CFG        12'h000
`define DTC_OFF_CTL        12'h00C
`define DTC_OFF_STAT       12'h010

// Control register field positions.
`define DTC_B_EDGE_HI      11
`define DTC_B_EDGE_LO      10
`define DTC_B_FREEZE       9
`define DTC_B_EN           8
`define DTC_A_PWM_INV      6
`define DTC_A_TRIG_EN      5
`define DTC_RTC_EN         4
`define DTC_A_EDGE_HI      3
`define DTC_A_EDGE_LO      2
`define DTC_A_FREEZE       1
`define DTC_A_EN           0

// Writable bits of the control register; bit 7 and bits 12 upward stay zero.
`define DTC_CTL_RW_MASK    32'h00000F7F

// Reset values.
`define DTC_CTL_RST        12'h000
`define DTC_CFG_RST        3'h0

// Global configuration codes.
`define DTC_CFG_T32        3'h0
`define DTC_CFG_RTC        3'h1

`endif

// >>> dtc_pkg.sv
// Types shared by the dual timer control block and its edge selector.
// Assumes the defines header is on the include path.
package dtc_pkg;

    // Capture edge selection codes; code 2 is reserved and yields no event.
    typedef enum logic [1:0] {
        DTC_EDGE_RISE = 2'h0,
        DTC_EDGE_FALL = 2'h1,
        DTC_EDGE_RSVD = 2'h2,
        DTC_EDGE_BOTH = 2'h3
    } dtc_edge_e;

    // State of one edge selector.
    typedef struct packed {
        logic pin_prev;
        logic event_out;
    } dtc_edge_s;

    // State of the control block.
    typedef struct packed {
        logic [11:0] ctl;
        logic [2:0]  cfg;
        logic [31:0] rdata;
        logic        err;
        logic        a_cnt;
        logic        b_cnt;
        logic        rtc_run;
        logic        pwm;
        logic        trig;
    } dtc_state_s;

endpackage : dtc_pkg

// >>> dtc_edge_select.sv
// Capture edge selector for one timer half.
// Assumes the capture pin is synchronous to pclk and arm comes from a flip-flop.
`timescale 1ns/10ps
`include "dtc_defines.svh"

module dtc_edge_select (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control.
    input  wire logic [1:0] edge_sel,
    input  wire logic       arm,
    // Capture pin and event.
    input  wire logic       pin_in,
    output logic            capture_event
);

    dtc_pkg::dtc_edge_s st_reg;
    dtc_pkg::dtc_edge_s st_next;
    logic               rise;
    logic               fall;

    // Edge decode; the reserved code never produces an event.
    always_comb begin
        rise             = pin_in & ~st_reg.pin_prev;
        fall             = ~pin_in & st_reg.pin_prev;
        st_next          = st_reg;
        st_next.pin_prev = pin_in;
        case (dtc_pkg::dtc_edge_e'(edge_sel))
            dtc_pkg::DTC_EDGE_RISE: st_next.event_out = arm & rise;
            dtc_pkg::DTC_EDGE_FALL: st_next.event_out = arm & fall;
            dtc_pkg::DTC_EDGE_BOTH: st_next.event_out = arm & (rise | fall);
            default:                st_next.event_out = 1'b0;
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign capture_event = st_reg.event_out;

    chk_rise_event: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_sel == 2'h0 && arm && pin_in && !st_reg.pin_prev) |=> capture_event)
        else $error("Rising edge did not raise the capture event.");
    chk_edge_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (edge_sel == 2'h2) |=> !capture_event)
        else $error("Reserved edge code produced a capture event.");

endmodule : dtc_edge_select

// >>> dtc_far_model.sv
// Far-side model of the timer control block: A counter sources and an ADC trigger input.
// Assumes the bench supplies pclk, presetn and the ADC enable and source select levels.
`timescale 1ns/10ps

module dtc_far_model (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // ADC setup levels.
    input  wire logic       adc_on,
    input  wire logic       adc_src_timer,
    // Timer side.
    input  wire logic       a_adc_trigger,
    output logic            a_pwm_raw,
    output logic            a_timeout_pulse,
    output logic [7:0]      conversions
);
    logic [2:0] phase;

    // An uneven PWM and a timeout pulse every eight cycles, so a stuck output shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase           <= 3'h0;
            a_pwm_raw       <= 1'b0;
            a_timeout_pulse <= 1'b0;
            conversions     <= 8'h00;
        end else begin
            phase           <= phase + 3'h1;
            a_pwm_raw       <= (phase < 3'h3);
            a_timeout_pulse <= (phase == 3'h5);
            // The converter ignores the trigger unless it is on and listens to this timer.
            if (adc_on && adc_src_timer && a_adc_trigger) begin
                conversions <= conversions + 8'h01;
            end
        end
    end
endmodule : dtc_far_model

// >>> tb_top.sv
// Self-checking bench of the dual timer control block.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/10ps
`include "dtc_defines.svh"

module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        debug_halt, a_pin, b_pin, a_pwm_raw, a_timeout_pulse;
    logic        a_count_en, b_count_en, rtc_count_run, a_capture_event, b_capture_event;
    logic        cfg_single32, cfg_rtc32, cfg_split16, a_pwm_out, a_adc_trigger;
    logic        adc_on, adc_src_timer, err;
    logic [7:0]  conversions;
    int          failures, checked;

    dtc_timer_control u_dtc_timer_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .debug_halt(debug_halt),
        .a_capture_pin(a_pin), .b_capture_pin(b_pin), .a_pwm_raw(a_pwm_raw),
        .a_timeout_pulse(a_timeout_pulse), .a_count_en(a_count_en), .b_count_en(b_count_en),
        .rtc_count_run(rtc_count_run), .a_capture_event(a_capture_event),
        .b_capture_event(b_capture_event), .cfg_single32(cfg_single32),
        .cfg_rtc32(cfg_rtc32), .cfg_split16(cfg_split16), .a_pwm_out(a_pwm_out),
        .a_adc_trigger(a_adc_trigger));

    dtc_far_model u_dtc_far_model (.pclk(pclk), .presetn(presetn), .adc_on(adc_on),
        .adc_src_timer(adc_src_timer), .a_adc_trigger(a_adc_trigger), .a_pwm_raw(a_pwm_raw),
        .a_timeout_pulse(a_timeout_pulse), .conversions(conversions));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns period.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Compare a seen value with the expected one and count the outcome.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Print the counts and the verdict, then stop.
    task automatic results;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // One APB transfer; the request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Write one register and let the controls settle for three edges.
    task automatic wr_set(input logic [11:0] addr, input logic [31:0] wd);
        apb(1'b1, addr, wd);
        repeat (3) @(posedge pclk);
    endtask : wr_set

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, reserved bits and an unmapped address.
    task automatic t_regs;
        apb(1'b0, `DTC_OFF_CTL, 32'h0);
        check("ctl reset", rd, 32'h00000000);
        check("single32 reset", cfg_single32, 1'b1);
        wr_set(`DTC_OFF_CTL, 32'hFFFFFFFF);
        apb(1'b0, `DTC_OFF_CTL, 32'h0);
        check("ctl reserved", rd, 32'h00000F7F);
        apb(1'b1, 12'h004, 32'hFFFFFFFF);
        check("unmapped write err", err, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        check("unmapped read err", err, 1'b1);
        check("unmapped read data", rd, 32'h00000000);
        wr_set(`DTC_OFF_CTL, 32'h0);
    endtask : t_regs

    // Configuration codes 0, 1, 4 and 7 decode to their arrangement, reserved code 2 to none.
    task automatic t_cfg;
        logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
        foreach (codes[i]) begin
            wr_set(`DTC_OFF_CFG, {29'h0, codes[i]});
            check("single32", cfg_single32, codes[i] == 3'h0);
            check("rtc32", cfg_rtc32, codes[i] == 3'h1);
            check("split16", cfg_split16, codes[i][2]);
        end
    endtask : t_cfg

    // Enables and debug freeze in split mode; the freeze bit only matters under halt.
    task automatic t_freeze;
        logic [31:0] ctl [6] = '{32'h103, 32'h103, 32'h303, 32'h303, 32'h200, 32'h101};
        logic        hlt [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
        logic        ea  [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
        logic        eb  [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        wr_set(`DTC_OFF_CFG, 32'h4);
        foreach (ctl[i]) begin
            debug_halt <= hlt[i];
            wr_set(`DTC_OFF_CTL, ctl[i]);
            check("a_count_en", a_count_en, ea[i]);
            check("b_count_en", b_count_en, eb[i]);
            apb(1'b0, `DTC_OFF_STAT, 32'h0);
            check("status enables", rd[1:0], {eb[i], ea[i]});
        end
        debug_halt <= 1'b0;
    endtask : t_freeze

    // RTC counting follows its enable bit in RTC arrangement and stops when cleared.
    task automatic t_rtc;
        wr_set(`DTC_OFF_CFG, 32'h1);
        wr_set(`DTC_OFF_CTL, 32'h10);
        check("rtc run", rtc_count_run, 1'b1);
        wr_set(`DTC_OFF_CTL, 32'h0);
        check("rtc stop", rtc_count_run, 1'b0);
    endtask : t_rtc

    // Each edge code on both halves: one rising then one falling pin edge.
    task automatic t_edges;
        int exp_n [4] = '{1, 1, 0, 2};
        int na, nb;
        wr_set(`DTC_OFF_CFG, 32'h4);
        for (int c = 0; c < 4; c++) begin
            wr_set(`DTC_OFF_CTL, 32'h101 | (c << 10) | (c << 2));
            na = 0;
            nb = 0;
            for (int k = 0; k < 10; k++) begin
                a_pin <= (k < 5);
                b_pin <= (k < 5);
                @(posedge pclk);
                na += (a_capture_event === 1'b1);
                nb += (b_capture_event === 1'b1);
            end
            check("a events", na, exp_n[c]);
            check("b events", nb, exp_n[c]);
        end
    endtask : t_edges

    // PWM invert and ADC trigger gating, with the converter listening or not.
    task automatic t_pwm;
        logic       prev_raw, prev_pulse, inv, te;
        logic [7:0] start;
        for (int i = 0; i < 4; i++) begin
            inv = i[0];
            te = i[1];
            adc_src_timer <= i[0];
            wr_set(`DTC_OFF_CTL, {25'h0, inv, te, 5'h0});
            start = conversions;
            prev_raw = a_pwm_raw;
            prev_pulse = a_timeout_pulse;
            repeat (16) begin
                @(posedge pclk);
                check("pwm out", a_pwm_out, prev_raw ^ inv);
                check("adc trigger", a_adc_trigger, prev_pulse & te);
                prev_raw = a_pwm_raw;
                prev_pulse = a_timeout_pulse;
            end
            check("conversions", conversions != start, te & i[0]);
        end
    endtask : t_pwm

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 16 cycles, then every scenario in turn.
    initial begin
        failures = 0;
        checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, debug_halt, a_pin, b_pin} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        adc_on = 1'b1;
        adc_src_timer = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cfg();
        t_freeze();
        t_rtc();
        t_edges();
        t_pwm();
        results();
    end
endmodule : tb_top
